/* File: hw/srx_cfg.svh */
// Constants for the serial receive control block
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH

// ==========================================================
// Register offsets
`define SRX_ADDR_W 8
`define SRX_OFS_CTRL1 8'h13
`define SRX_OFS_CTRL2 8'h14
`define SRX_OFS_CTRL3 8'h15
`define SRX_OFS_STAT1 8'h16
`define SRX_OFS_STAT2 8'h17
`define SRX_OFS_DATA 8'h18
`define SRX_OFS_BRKCTL 8'h1F

// ==========================================================
// Field positions
`define SRX_C2_RX_FULL_IRQ_ENABLE 5
`define SRX_C2_QUIET_LINE_IRQ_ENABLE 4
`define SRX_C2_TE 3
`define SRX_C2_RE 2
`define SRX_C2_STBY 1
`define SRX_C3_R8 7
`define SRX_C3_RX_DMA_REQUEST_ENABLE 5
`define SRX_C3_OVERRUN_IRQ_ENABLE 3
`define SRX_C3_NOISE_IRQ_ENABLE 2
`define SRX_C3_FRAMING_IRQ_ENABLE 1
`define SRX_C3_PARITY_IRQ_ENABLE 0
`define SRX_S2_BRK 1
`define SRX_S2_RPF 0
`define SRX_BC_BREAK_CLEAR_FLAG_ENABLE 7

// ==========================================================
// Reset values and counts
`define SRX_RST_BYTE 8'h00
`define SRX_RST_CHAR 9'h000
`define SRX_QUIET_8BIT 4'hA
`define SRX_QUIET_9BIT 4'hB
`define SRX_BITS_8 4'h8
`define SRX_BITS_9 4'h9

`endif

/* File: hw/srx_pkg.sv */
// Types shared by the serial receive control block
package srx_pkg;

  // ==========================================================
  // Control register 1 layout
  typedef struct packed {
    logic loops;
    logic enable;
    logic txInv;
    logic nineBit;
    logic wakeSel;
    logic quietCountStartSelect;
    logic parityEn;
    logic parityOdd;
  } srx_ctrl1_s;

  // ==========================================================
  // Receiver status flags, in status register 1 order
  typedef struct packed {
    logic receiveFullFlag;
    logic quietFlag;
    logic overrunFlag;
    logic noiseFlag;
    logic framingErrorFlag;
    logic parityErrorFlag;
  } srx_flags_s;

  // ==========================================================
  // Receiver frame states
  typedef enum logic [1:0] {
    SRX_HUNT,
    SRX_DATA,
    SRX_STOP
  } srx_state_e;

endpackage : srx_pkg

/* File: hw/srx_rx_ctrl.sv */
// Serial receiver control: standby, flags, requests, break protection, pins
//
// Behaviour
// RQ1 - Standby bit suppresses all receiver requests; code gates rxIrq and dmaReq only, not errIrq
// RQ2 - Address-mark wakeup clears standby, sets full
// RQ3 - Idle wakeup clears standby, no flags set
// RQ4 - Quiet count starts after start or stop
// RQ5 - Standby on idle line may wake immediately
// RQ6 - Full flag gives CPU or DMA request
// RQ7 - Quiet flag after 10/11 ones, enable gated
// RQ8 - DMA enable suppresses all receiver CPU requests; code gates rxIrq only, not errIrq
// RQ9 - Overrun keeps old character, drops new one
// RQ10 - Noise flag; overrun/noise request error interrupt
// RQ11 - Zero at stop bit sets framing error
// RQ12 - Failed parity check sets parity error
// RQ13 - DMA data read clears only full flag
// RQ14 - Full enable clear disables DMA service
// RQ15 - Status read then data read clears errors
// RQ16 - New byte loads after read, overrun stays
// RQ17 - Wait mode: active, enabled requests wake
// RQ18 - Stop mode halts, keeps register contents
// RQ19 - Break clear enable lets flags clear
// RQ20 - Break protection; armed clear finishes after break
// RQ21 - Enabled module drives transmit pin
// RQ22 - Enabled module treats receive pin as input
// RQ23 - Count start select one means after stop
// RQ24 - Wakeup select one means address mark
// RQ25 - Error request ORs flags with enables
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "srx_cfg.svh"

module srx_rx_ctrl
  import srx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [`SRX_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // DMA channel
  input wire logic dmaRead,
  output logic dmaReq,
  // Bit sampler: one tick per bit centre
  input wire logic bitTick,
  input wire logic bitNoise,
  // System state
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic debugBreak,
  // Port direction bits 1 and 2
  input wire logic portEDirectionBit1,
  input wire logic portEDirectionBit2,
  input wire logic portTxOut,
  input wire logic portRxOut,
  // Transmitter serial data
  input wire logic txSerial,
  // Pins
  input wire logic rxPinIn,
  output logic rxPinOut,
  output logic rxPinOeN,
  output logic txPinOut,
  output logic txPinOeN,
  // Requests
  output logic rxIrq,
  output logic errIrq,
  output logic wakeReq
);

  // ==========================================================
  // Registers
  srx_ctrl1_s ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl3_reg;
  logic break_clear_flag_enable_reg;
  srx_flags_s flags_reg;
  srx_flags_s armed_reg;
  logic brk_reg;
  logic brkArmed_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  srx_state_e state_reg;
  logic [3:0] bitIdx_reg;
  logic [8:0] shift_reg;
  logic noiseAcc_reg;
  logic [3:0] quiet_reg;

  // ==========================================================
  // Decode
  logic enabled;
  logic running;
  logic standby;
  logic protect;
  logic rdStat1;
  logic rdStat2;
  logic dataRead;
  logic dmaEn;
  logic fullClr;
  logic charDone;
  logic frameErr;
  logic parityBad;
  logic isBreak;
  logic msb;
  logic accept;
  logic loadChar;
  logic overrun;
  logic quietHit;
  logic lineIdle;
  logic rxBit;
  logic [3:0] nBits;
  logic [3:0] quietLim;
  logic [8:0] charBits;
  logic [7:0] stat1;
  logic [7:0] rdMux;

  function automatic logic hit(input logic [`SRX_ADDR_W-1:0] a,
                               input logic [`SRX_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign enabled = ctrl1_reg.enable;
  assign running = enabled && ctrl2_reg[`SRX_C2_RE] && !stopMode; // see RQ18
  assign standby = ctrl2_reg[`SRX_C2_STBY];
  assign protect = debugBreak && !break_clear_flag_enable_reg; // see RQ20
  assign rdStat1 = regRd && hit(regAddr, `SRX_OFS_STAT1) && !protect; // see RQ15
  assign rdStat2 = regRd && hit(regAddr, `SRX_OFS_STAT2) && !protect;
  assign dataRead = ((regRd && hit(regAddr, `SRX_OFS_DATA)) || dmaRead) && !protect;
  assign dmaEn = ctrl2_reg[`SRX_C2_RX_FULL_IRQ_ENABLE] && ctrl3_reg[`SRX_C3_RX_DMA_REQUEST_ENABLE]; // see RQ14
  // DMA read alone clears full while dmaEn is set; otherwise the armed two-step is needed
  assign fullClr = dataRead && ((dmaRead && dmaEn) || armed_reg.receiveFullFlag); // see RQ13

  // Receive pin seen only while enabled
  assign rxBit = enabled ? rxPinIn : 1'b1; // see RQ22
  assign nBits = ctrl1_reg.nineBit ? `SRX_BITS_9 : `SRX_BITS_8;
  assign quietLim = ctrl1_reg.nineBit ? `SRX_QUIET_9BIT : `SRX_QUIET_8BIT;
  assign charBits = ctrl1_reg.nineBit ? shift_reg : {1'b0, shift_reg[7:0]};
  assign msb = ctrl1_reg.nineBit ? shift_reg[8] : shift_reg[7];

  // ==========================================================
  // Character completion
  assign charDone = running && bitTick && (state_reg == SRX_STOP);
  assign frameErr = !rxBit; // see RQ11
  assign parityBad = ctrl1_reg.parityEn && ((^charBits) != ctrl1_reg.parityOdd); // see RQ12
  assign isBreak = frameErr && (charBits == `SRX_RST_CHAR);
  // In standby only an address mark is taken in
  assign accept = !standby || (ctrl1_reg.wakeSel && msb); // see RQ2 RQ24
  assign overrun = charDone && accept && flags_reg.receiveFullFlag && !fullClr; // see RQ9
  assign loadChar = charDone && accept && !overrun; // see RQ16

  // ==========================================================
  // Quiet line detection
  assign lineIdle = (quiet_reg == quietLim);
  assign quietHit = running && bitTick && rxBit && (state_reg == SRX_HUNT) &&
                    (quiet_reg + 4'h1 == quietLim); // see RQ7

  // ==========================================================
  // Frame sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SRX_HUNT;
      bitIdx_reg <= 4'h0;
      shift_reg <= `SRX_RST_CHAR;
      noiseAcc_reg <= 1'b0;
    end else if (running && bitTick) begin
      unique case (state_reg)
        SRX_HUNT: begin
          if (!rxBit) begin
            state_reg <= SRX_DATA;
            bitIdx_reg <= 4'h0;
            shift_reg <= `SRX_RST_CHAR;
            noiseAcc_reg <= bitNoise;
          end
        end
        SRX_DATA: begin
          shift_reg[bitIdx_reg] <= rxBit;
          noiseAcc_reg <= noiseAcc_reg || bitNoise;
          bitIdx_reg <= bitIdx_reg + 4'h1;
          if (bitIdx_reg == nBits - 4'h1) begin
            state_reg <= SRX_STOP;
          end
        end
        SRX_STOP: begin
          state_reg <= SRX_HUNT;
        end
      endcase
    end
  end

  // Consecutive ones; with select set, counting restarts until after the stop bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_reg <= 4'h0;
    end else if (running && bitTick) begin
      if (!rxBit || (ctrl1_reg.quietCountStartSelect && state_reg != SRX_HUNT)) begin
        quiet_reg <= 4'h0; // see RQ4 RQ23
      end else if (!lineIdle) begin
        quiet_reg <= quiet_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg <= `SRX_RST_BYTE;
      ctrl3_reg <= `SRX_RST_BYTE;
      break_clear_flag_enable_reg <= 1'b0;
    end else begin
      if (regWr && hit(regAddr, `SRX_OFS_CTRL1)) begin
        ctrl1_reg <= regWdata;
      end
      if (regWr && hit(regAddr, `SRX_OFS_CTRL3)) begin
        ctrl3_reg[5:0] <= regWdata[5:0];
      end
      if (loadChar) begin
        ctrl3_reg[`SRX_C3_R8] <= msb;
      end
      if (regWr && hit(regAddr, `SRX_OFS_BRKCTL)) begin
        break_clear_flag_enable_reg <= regWdata[`SRX_BC_BREAK_CLEAR_FLAG_ENABLE];
      end
    end
  end

  // Control 2; standby bit cleared by wakeup, wakeup wins over a write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_reg <= `SRX_RST_BYTE;
    end else begin
      if (regWr && hit(regAddr, `SRX_OFS_CTRL2)) begin
        ctrl2_reg[7:4] <= regWdata[7:4];
        ctrl2_reg[1:0] <= regWdata[1:0];
        if (enabled) begin
          ctrl2_reg[3:2] <= regWdata[3:2];
        end
      end
      if (standby && running) begin
        if (ctrl1_reg.wakeSel && loadChar) begin
          ctrl2_reg[`SRX_C2_STBY] <= 1'b0; // see RQ2
        end
        if (!ctrl1_reg.wakeSel && (quietHit || lineIdle)) begin
          ctrl2_reg[`SRX_C2_STBY] <= 1'b0; // see RQ3 RQ5
        end
      end
    end
  end

  // ==========================================================
  // Data register keeps the old character on overrun
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= `SRX_RST_BYTE;
    end else if (loadChar) begin
      data_reg <= shift_reg[7:0]; // see RQ9 RQ16
    end
  end

  // ==========================================================
  // Status flags: set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= '0;
    end else begin
      if (fullClr || loadChar) begin
        flags_reg.receiveFullFlag <= loadChar; // see RQ2 RQ13
      end
      if (dataRead && armed_reg.quietFlag) begin
        flags_reg.quietFlag <= 1'b0;
      end
      if (quietHit && !standby) begin
        flags_reg.quietFlag <= 1'b1; // see RQ3 RQ7
      end
      // Error flags clear only on the armed two-step, never by the DMA read alone
      if (dataRead && armed_reg.overrunFlag) begin
        flags_reg.overrunFlag <= 1'b0; // see RQ15 RQ16
      end
      if (dataRead && armed_reg.noiseFlag) begin
        flags_reg.noiseFlag <= 1'b0;
      end
      if (dataRead && armed_reg.framingErrorFlag) begin
        flags_reg.framingErrorFlag <= 1'b0;
      end
      if (dataRead && armed_reg.parityErrorFlag) begin
        flags_reg.parityErrorFlag <= 1'b0;
      end
      if (overrun) begin
        flags_reg.overrunFlag <= 1'b1; // see RQ9
      end
      if (charDone && accept && (noiseAcc_reg || bitNoise)) begin
        flags_reg.noiseFlag <= 1'b1; // see RQ10
      end
      if (loadChar && frameErr) begin
        flags_reg.framingErrorFlag <= 1'b1; // see RQ11
      end
      if (loadChar && parityBad) begin
        flags_reg.parityErrorFlag <= 1'b1; // see RQ12
      end
    end
  end

  // Two-step arming; held through a protected break
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= '0;
    end else if (rdStat1) begin
      armed_reg <= flags_reg; // see RQ15 RQ19
    end else if (dataRead) begin
      armed_reg <= '0; // see RQ20
    end
  end

  // Break detect flag, cleared by status 2 read then data read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      brk_reg <= 1'b0;
      brkArmed_reg <= 1'b0;
    end else begin
      if (rdStat2) begin
        brkArmed_reg <= brk_reg;
      end else if (dataRead) begin
        brkArmed_reg <= 1'b0;
      end
      if (loadChar && isBreak) begin
        brk_reg <= 1'b1;
      end else if (dataRead && brkArmed_reg) begin
        brk_reg <= 1'b0; // see RQ13
      end
    end
  end

  // ==========================================================
  // Read data, valid in the cycle after the strobe only
  assign stat1 = {2'b00, flags_reg};
  always_comb begin
    rdMux = `SRX_RST_BYTE;
    if (hit(regAddr, `SRX_OFS_CTRL1)) begin
      rdMux = ctrl1_reg;
    end else if (hit(regAddr, `SRX_OFS_CTRL2)) begin
      rdMux = ctrl2_reg;
    end else if (hit(regAddr, `SRX_OFS_CTRL3)) begin
      rdMux = ctrl3_reg;
    end else if (hit(regAddr, `SRX_OFS_STAT1)) begin
      rdMux = stat1;
    end else if (hit(regAddr, `SRX_OFS_STAT2)) begin
      rdMux[`SRX_S2_BRK] = brk_reg;
      rdMux[`SRX_S2_RPF] = (state_reg != SRX_HUNT);
    end else if (hit(regAddr, `SRX_OFS_DATA)) begin
      rdMux = data_reg;
    end else if (hit(regAddr, `SRX_OFS_BRKCTL)) begin
      rdMux[`SRX_BC_BREAK_CLEAR_FLAG_ENABLE] = break_clear_flag_enable_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= `SRX_RST_BYTE;
    end else begin
      rdata_reg <= regRd ? rdMux : `SRX_RST_BYTE;
    end
  end
  assign regRdata = rdata_reg;

  // ==========================================================
  // Requests
  assign rxIrq = !standby && !ctrl3_reg[`SRX_C3_RX_DMA_REQUEST_ENABLE] && // see RQ1 RQ8
                 ((ctrl2_reg[`SRX_C2_RX_FULL_IRQ_ENABLE] && flags_reg.receiveFullFlag) || // see RQ6
                  (ctrl2_reg[`SRX_C2_QUIET_LINE_IRQ_ENABLE] && flags_reg.quietFlag)); // see RQ7
  assign dmaReq = !standby && dmaEn && flags_reg.receiveFullFlag; // see RQ6 RQ14
  assign errIrq = (ctrl3_reg[`SRX_C3_OVERRUN_IRQ_ENABLE] && flags_reg.overrunFlag) || // see RQ25 RQ10
                  (ctrl3_reg[`SRX_C3_NOISE_IRQ_ENABLE] && flags_reg.noiseFlag) ||
                  (ctrl3_reg[`SRX_C3_FRAMING_IRQ_ENABLE] && flags_reg.framingErrorFlag) ||
                  (ctrl3_reg[`SRX_C3_PARITY_IRQ_ENABLE] && flags_reg.parityErrorFlag);
  assign wakeReq = waitMode && (rxIrq || errIrq); // see RQ17

  // ==========================================================
  // Pins; enable low means driven
  assign txPinOut = enabled ? txSerial : portTxOut;
  assign txPinOeN = enabled ? 1'b0 : !portEDirectionBit2; // see RQ21
  assign rxPinOut = portRxOut;
  assign rxPinOeN = enabled ? 1'b1 : !portEDirectionBit1; // see RQ22

endmodule : srx_rx_ctrl

/* File: tb/srx_rx_ctrl_asserts.sv */
// Port assertions for the serial receive control block
`timescale 1ns/1ps
`include "srx_cfg.svh"
module srx_rx_ctrl_asserts
  import srx_pkg::*;
(
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`SRX_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic dmaRead,
  // System state and port bits
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic portEDirectionBit2,
  input wire logic txSerial,
  // Outputs watched
  input wire logic dmaReq,
  input wire logic rxPinOeN,
  input wire logic txPinOut,
  input wire logic txPinOeN,
  input wire logic rxIrq,
  input wire logic errIrq,
  input wire logic wakeReq
);
  // ====
  // Shadow of the control bits
  logic enReg, ieReg, dmaReg;
  logic [3:0] errEnReg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enReg <= 1'b0;
      ieReg <= 1'b0;
      dmaReg <= 1'b0;
      errEnReg <= 4'h0;
    end else if (regWr) begin
      if (regAddr == `SRX_OFS_CTRL1) enReg <= regWdata[6];
      if (regAddr == `SRX_OFS_CTRL2) ieReg <= regWdata[5];
      if (regAddr == `SRX_OFS_CTRL3) dmaReg <= regWdata[5];
      if (regAddr == `SRX_OFS_CTRL3) errEnReg <= regWdata[3:0];
    end
  end
  // ====
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_dma_mutes_cpu: assert property (dmaReg |-> !rxIrq)
    else $error("cpu request while dma enabled");
  chk_dma_needs_ie: assert property (dmaReq |-> ieReg && dmaReg)
    else $error("dma request without both enables");
  chk_tx_pin_drive: assert property (enReg |-> !txPinOeN && txPinOut == txSerial)
    else $error("transmit pin not driven");
  chk_tx_port_dir: assert property (!enReg |-> txPinOeN == !portEDirectionBit2)
    else $error("transmit pin ignores port direction");
  chk_rx_pin_input: assert property (enReg |-> rxPinOeN)
    else $error("receive pin driven while enabled");
  chk_err_gated: assert property (errIrq |-> errEnReg != 4'h0)
    else $error("error request with no enable");
  chk_wait_wakes: assert property (waitMode && (rxIrq || errIrq) |-> wakeReq)
    else $error("enabled request does not wake");
  chk_stop_holds: assert property (stopMode && $past(stopMode) && !$past(regWr)
    && !$past(regRd) && !$past(dmaRead) |-> $stable(rxIrq) && $stable(errIrq))
    else $error("requests changed in stop mode");
endmodule : srx_rx_ctrl_asserts

bind srx_rx_ctrl srx_rx_ctrl_asserts chk (.core_clk, .nrst, .regAddr, .regWdata, .regWr,
  .regRd, .dmaRead, .waitMode, .stopMode, .portEDirectionBit2, .txSerial, .dmaReq,
  .rxPinOeN, .txPinOut, .txPinOeN, .rxIrq, .errIrq, .wakeReq);

/* File: tb/srx_rx_ctrl_test.sv */
// Self-checking bench for the serial receive control block
`timescale 1ns/1ps
`include "srx_cfg.svh"
module srx_rx_ctrl_test
  import srx_pkg::*;
;
  localparam logic [7:0] C1 = `SRX_OFS_CTRL1;
  localparam logic [7:0] C2 = `SRX_OFS_CTRL2;
  localparam logic [7:0] C3 = `SRX_OFS_CTRL3;
  localparam logic [7:0] ST = `SRX_OFS_STAT1;
  localparam logic [7:0] DT = `SRX_OFS_DATA;
  logic core_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, dmaRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rb;
  logic waitMode = 1'b0, stopMode = 1'b0, debugBreak = 1'b0;
  logic portEDirectionBit1 = 1'b1, portEDirectionBit2 = 1'b0;
  logic portTxOut = 1'b0, portRxOut = 1'b0, txSerial = 1'b0;
  logic dmaReq, rxPinOeN, txPinOut, txPinOeN, rxIrq, errIrq, wakeReq, rxLine, tick, noise;
  logic rxPinOut;
  logic [31:0] lfsr = 32'h0CC08176;
  logic [7:0] expQ[$], mskQ[$];
  logic rdPend = 1'b0;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [7:0] tC[3] = '{8'h40, 8'h40, 8'h42};
  logic [7:0] tD[3] = '{8'h55, 8'h55, 8'h01};
  logic [7:0] tF[3] = '{8'h22, 8'h24, 8'h21};
  logic tS[3] = '{1'b0, 1'b1, 1'b1};
  logic tN[3] = '{1'b0, 1'b1, 1'b0};

  srx_rx_ctrl dut (.core_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .dmaRead, .dmaReq, .bitTick(tick), .bitNoise(noise), .waitMode, .stopMode, .debugBreak,
    .portEDirectionBit1, .portEDirectionBit2, .portTxOut, .portRxOut, .txSerial,
    .rxPinIn(rxLine), .rxPinOut, .rxPinOeN, .txPinOut, .txPinOeN, .rxIrq, .errIrq, .wakeReq);
  srx_tx_model tx (.core_clk, .rxLine, .tick, .noise);

  // ====
  // Clock, random pins, timeout
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRnd
  always @(posedge core_clk) begin
    lfsr <= nextRnd(lfsr);
    txSerial <= lfsr[0];
    portTxOut <= lfsr[1];
    portRxOut <= lfsr[2];
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ====
  // Compare tasks and read monitor
  task automatic chkByte(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (e & m)) begin
      n_mismatch++;
      $display("[ERR] regRdata exp %h got %h", e, got);
    end
  endtask : chkByte
  task automatic chkBit(input string nm, input logic got, input logic e);
    #1;
    n_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %b got %b", nm, e, got);
    end
  endtask : chkBit
  always @(posedge core_clk) rdPend <= regRd;
  always @(negedge core_clk) begin
    if (rdPend) begin
      chkByte(regRdata, expQ.pop_front(), mskQ.pop_front());
    end
    chkBit("rxPinOut", rxPinOut, portRxOut);
  end
  // ====
  // Register port tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  task automatic dmaRd;
    dmaRead <= 1'b1;
    @(posedge core_clk);
    dmaRead <= 1'b0;
    @(posedge core_clk);
  endtask : dmaRd
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // ====
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chkBit("txPinOeN", txPinOeN, 1'b1);
    chkBit("rxPinOeN", rxPinOeN, 1'b0);
    for (int a = 8'h13; a < 8'h1B; a++) rd(a[7:0], 8'h00, 8'hFF);
    wr(C1, 8'h40);
    wr(C2, 8'h24);
    wr(C3, 8'h0F);
    chkBit("txPinOeN", txPinOeN, 1'b0);
    chkBit("rxPinOeN", rxPinOeN, 1'b1);
    rb = lfsr[7:0];
    tx.sendChar(rb, 1'b1, 1'b0);
    chkBit("rxIrq", rxIrq, 1'b1);
    rd(ST, 8'h20, 8'hFF);
    rd(DT, rb, 8'hFF);
    rd(ST, 8'h00, 8'hFF);
    tx.sendChar(8'h11, 1'b1, 1'b0);
    tx.sendChar(8'h22, 1'b1, 1'b0);
    chkBit("errIrq", errIrq, 1'b1);
    rd(DT, 8'h11, 8'hFF);
    wr(C3, 8'h2F);
    chkBit("rxIrq", rxIrq, 1'b0);
    chkBit("dmaReq", dmaReq, 1'b1);
    dmaRd();
    rd(ST, 8'h08, 8'hFB);
    tx.sendChar(8'h33, 1'b1, 1'b0);
    rd(ST, 8'h28, 8'hFB);
    dmaRd();
    rd(ST, 8'h00, 8'hFF);
    rd(DT, 8'h33, 8'hFF);
    wr(C2, 8'h04);
    tx.sendChar(8'h44, 1'b1, 1'b0);
    chkBit("dmaReq", dmaReq, 1'b0);
    dmaRd();
    rd(ST, 8'h20, 8'hFF);
    rd(DT, 8'h44, 8'hFF);
    rd(ST, 8'h00, 8'hFF);
    wr(C3, 8'h0F);
    wr(C2, 8'h24);
    for (int i = 0; i < 3; i++) begin
      wr(C1, tC[i]);
      tx.sendChar(tD[i], tS[i], tN[i]);
      chkBit("errIrq", errIrq, 1'b1);
      rd(ST, tF[i], 8'hFF);
      rd(DT, tD[i], 8'hFF);
      chkBit("errIrq", errIrq, 1'b0);
    end
    wr(C1, 8'h50);
    tx.sendChar9(9'h1A5);
    rd(C3, 8'h8F, 8'hFF);
    rd(ST, 8'h20, 8'hFF);
    rd(DT, 8'hA5, 8'hFF);
    wr(C1, 8'h44);
    wr(C2, 8'h14);
    tx.sendChar(8'hFF, 1'b1, 1'b0);
    tx.idle(9);
    chkBit("rxIrq", rxIrq, 1'b0);
    tx.idle(1);
    chkBit("rxIrq", rxIrq, 1'b1);
    rd(ST, 8'h30, 8'hFF);
    rd(DT, 8'hFF, 8'hFF);
    wr(C1, 8'h48);
    wr(C2, 8'h26);
    tx.sendChar(8'h12, 1'b1, 1'b0);
    rd(ST, 8'h00, 8'hFF);
    tx.sendChar(8'h92, 1'b1, 1'b0);
    chkBit("rxIrq", rxIrq, 1'b1);
    rd(C2, 8'h24, 8'hFF);
    rd(ST, 8'h20, 8'hFF);
    rd(DT, 8'h92, 8'hFF);
    wr(C1, 8'h44);
    wr(C2, 8'h26);
    tx.idle(10);
    rd(C2, 8'h24, 8'hFF);
    rd(ST, 8'h00, 8'hFF);
    wr(C2, 8'h26);
    rd(C2, 8'h24, 8'hFF);
    tx.sendChar(8'h5A, 1'b1, 1'b0);
    rd(ST, 8'h20, 8'hFF);
    debugBreak <= 1'b1;
    rd(DT, 8'h5A, 8'hFF);
    chkBit("rxIrq", rxIrq, 1'b1);
    debugBreak <= 1'b0;
    rd(DT, 8'h5A, 8'hFF);
    chkBit("rxIrq", rxIrq, 1'b0);
    wr(`SRX_OFS_BRKCTL, 8'h80);
    tx.sendChar(8'h6B, 1'b1, 1'b0);
    debugBreak <= 1'b1;
    rd(ST, 8'h20, 8'hFF);
    rd(DT, 8'h6B, 8'hFF);
    debugBreak <= 1'b0;
    chkBit("rxIrq", rxIrq, 1'b0);
    waitMode <= 1'b1;
    tx.sendChar(8'h7C, 1'b1, 1'b0);
    chkBit("wakeReq", wakeReq, 1'b1);
    wr(C3, 8'h2F);
    dmaRd();
    chkBit("dmaReq", dmaReq, 1'b0);
    waitMode <= 1'b0;
    stopMode <= 1'b1;
    tx.sendChar(8'h3C, 1'b1, 1'b0);
    stopMode <= 1'b0;
    rd(ST, 8'h00, 8'hEF);
    test_done();
  end
endmodule : srx_rx_ctrl_test

/* File: tb/srx_tx_model.sv */
// Remote serial transmitter model on the receive line
`timescale 1ns/1ps
module srx_tx_model (
  // Clock
  input wire logic core_clk,
  // Line and bit marks towards the receiver
  output logic rxLine,
  output logic tick,
  output logic noise
);
  initial begin
    rxLine = 1'b1;
    tick = 1'b0;
    noise = 1'b0;
  end
  // ====
  // One bit, two cycles long
  task automatic sendBit(input logic v, input logic nz);
    rxLine <= v;
    noise <= nz;
    tick <= 1'b1;
    @(posedge core_clk);
    tick <= 1'b0;
    noise <= 1'b0;
    @(posedge core_clk);
  endtask : sendBit
  // ====
  // Start, data LSB first, stop, then line back to mark
  task automatic sendChar(input logic [7:0] d, input logic sv, input logic nz);
    sendBit(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      sendBit(d[i], 1'b0);
    end
    sendBit(sv, nz);
    rxLine <= 1'b1;
  endtask : sendChar
  // Nine data bits, LSB first, good stop bit
  task automatic sendChar9(input logic [8:0] d);
    sendBit(1'b0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      sendBit(d[i], 1'b0);
    end
    sendBit(1'b1, 1'b0);
    rxLine <= 1'b1;
  endtask : sendChar9
  task automatic idle(input int n);
    repeat (n) sendBit(1'b1, 1'b0);
  endtask : idle
endmodule : srx_tx_model
